// File: verilog/host_port_index_and_status.v
// Operation
// - 8-bit index picks register when select low
// - cpu reads index, cpu writes ignored
// - index written only by host, select high
// - six-bit target code selects one register
// - order clear: 00 upper, 10 lower
// - order set: halves swapped
// - data window access toggles half select
// - 32-bit general status register for handshaking
// - cpu reads and writes general status
// - host reads status directly or indexed
// - status holds 16-bit field, bits 15:0
// - status field cleared only by power-on reset
// - strobes decode by select; both low forbidden
// - host data over sixteen shared lines
`timescale 1ns/1ns
`include "host_port_regs.vh"

module host_port_index_and_status (
	input wire clk_sys,
	input wire sys_rst,
	input wire port_rst,
	input wire host_chip_select_n,
	input wire register_select_pin,
	input wire host_write_strobe_n,
	input wire host_read_strobe_n,
	input wire [15:0] host_data_lines_in,
	output reg [15:0] host_data_lines_out,
	output reg host_data_lines_oe,
	input wire halfword_order_bit,
	input wire cpu_select,
	input wire cpu_reg,
	input wire cpu_write,
	input wire [31:0] cpu_wdata,
	output reg [31:0] cpu_rdata,
	output wire [5:0] target_select_field,
	output wire [1:0] halfword_select,
	input wire [31:0] target_rdata,
	output reg target_write,
	output reg target_read_done,
	output reg target_upper_half,
	output reg [15:0] target_wdata
);
	// ==================================================
	// pin synchronisers
	wire [3:0] ctrl_sync;
	wire [15:0] data_sync;
	wire cs_n;
	wire rs;
	wire wr_n;
	wire rd_n;
	wire [3:0] ctrl_pins;

	// strobes and data pass equal delays, so data seen under a low strobe is already settled
	assign ctrl_pins = {host_chip_select_n, register_select_pin, host_write_strobe_n,
		host_read_strobe_n};

	pin_sync #(
		.W(4),
		.IDLE(`PIN_CTRL_IDLE)
	) u_ctrl_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.pin_in(ctrl_pins),
		.pin_sync_out(ctrl_sync)
	);

	pin_sync #(
		.W(16),
		.IDLE(`PIN_DATA_IDLE)
	) u_data_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.pin_in(host_data_lines_in),
		.pin_sync_out(data_sync)
	);

	assign cs_n = ctrl_sync[3];
	assign rs = ctrl_sync[2];
	assign wr_n = ctrl_sync[1];
	assign rd_n = ctrl_sync[0];

	// ==================================================
	// access decode
	reg [`IDX_WIDTH-1:0] index;
	reg [`GSR_FIELD_WIDTH-1:0] status;
	reg wr_phase;
	reg rd_phase;
	reg latched_rs;
	reg [15:0] write_hold;
	wire wr_active;
	wire rd_active;
	wire wr_end;
	wire rd_start;
	wire rd_end;

	// both strobes low is a forbidden combination and is treated as idle
	assign wr_active = !cs_n && !wr_n && rd_n;
	assign rd_active = !cs_n && !rd_n && wr_n;
	assign wr_end = wr_phase && !wr_active;
	assign rd_start = rd_active && !rd_phase;
	assign rd_end = rd_phase && !rd_active;

	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			wr_phase <= 1'b0;
			rd_phase <= 1'b0;
			latched_rs <= 1'b0;
			write_hold <= 16'h0000;
		end else begin
			wr_phase <= wr_active;
			rd_phase <= rd_active;
			if (wr_active || rd_active) begin
				latched_rs <= rs;
			end
			// data is committed only at the strobe's release, so keep what was seen while low
			if (wr_active) begin
				write_hold <= data_sync;
			end
		end
	end

	// ==================================================
	// indexed register path
	wire [5:0] tgt;
	wire [1:0] half;
	wire tgt_status;
	wire tgt_window;
	wire [31:0] status_word;
	wire [31:0] indexed_word;
	wire lane_upper;
	wire [15:0] lane_rdata;
	wire [31:0] lane_merged;

	assign tgt = index[`IDX_TGT_MSB:`IDX_TGT_LSB];
	assign half = index[`IDX_HALF_MSB:`IDX_HALF_LSB];
	assign target_select_field = tgt;
	assign halfword_select = half;
	assign tgt_status = (tgt == `TGT_GENERAL_STATUS);
	assign tgt_window = (tgt == `TGT_DATA_WINDOW);
	assign status_word = {16'h0000, status};
	assign indexed_word = tgt_status ? status_word : target_rdata;

	// the host is trusted to set half select before the access
	halfword_lane u_lane (
		.word_in(indexed_word),
		.half_select(half),
		.order_swap(halfword_order_bit),
		.half_wdata(write_hold),
		.upper_half(lane_upper),
		.half_rdata(lane_rdata),
		.merged_word(lane_merged)
	);

	// ==================================================
	// index register
	reg [`IDX_WIDTH-1:0] next_index;
	wire host_idx_write;
	wire host_ind_write;
	wire host_ind_access_end;

	assign host_idx_write = wr_end && latched_rs;
	assign host_ind_write = wr_end && !latched_rs;
	assign host_ind_access_end = (wr_end || rd_end) && !latched_rs;

	// ==================================================
	// data window half walk
	reg [1:0] toggled_half;
	wire window_toggle;

	assign window_toggle = host_ind_access_end && tgt_window;

	// the odd codes fall to the default and restart the walk at the first half
	always @* begin
		case (half)
			`HALF_FIRST: begin
				toggled_half = `HALF_SECOND;
			end
			`HALF_SECOND: begin
				toggled_half = `HALF_FIRST;
			end
			default: begin
				toggled_half = `HALF_FIRST;
			end
		endcase
	end

	always @* begin
		next_index = index;
		if (host_idx_write) begin
			// codes outside the defined set are stored as given; the host must not use them
			next_index = write_hold[`IDX_WIDTH-1:0];
		end else if (window_toggle) begin
			next_index[`IDX_HALF_MSB:`IDX_HALF_LSB] = toggled_half;
		end
	end

	// the cpu path never reaches this register, so its writes are dropped
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			index <= `IDX_RESET;
		end else if (port_rst) begin
			index <= `IDX_RESET;
		end else begin
			index <= next_index;
		end
	end

	// ==================================================
	// general status register
	reg [`GSR_FIELD_WIDTH-1:0] next_status;
	wire cpu_status_write;
	wire host_status_write;

	assign cpu_status_write = cpu_select && cpu_write && (cpu_reg == `CPU_REG_STATUS);
	assign host_status_write = host_ind_write && tgt_status;

	always @* begin
		next_status = status;
		if (cpu_status_write) begin
			next_status = cpu_wdata[15:0];
		end
		// a host write lands after the cpu's, so the host wins a same-cycle clash
		if (host_status_write) begin
			next_status = lane_merged[15:0];
		end
	end

	// port_rst deliberately does not touch the status field
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			status <= `GSR_RESET;
		end else begin
			status <= next_status;
		end
	end

	// ==================================================
	// host read data and bus drive
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			host_data_lines_out <= 16'h0000;
			host_data_lines_oe <= 1'b0;
		end else begin
			host_data_lines_oe <= rd_active;
			// data is taken once at the read's start; a later change waits for the next read
			if (rd_start) begin
				if (rs) begin
					host_data_lines_out <= status;
				end else begin
					host_data_lines_out <= lane_rdata;
				end
			end
		end
	end

	// ==================================================
	// strobes toward the other indexed registers
	wire host_target_write;
	wire host_target_read_end;

	// the surrounding registers see one pulse per access and no status traffic
	assign host_target_write = host_ind_write && !tgt_status;
	assign host_target_read_end = rd_end && !latched_rs && !tgt_status;

	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			target_write <= 1'b0;
			target_read_done <= 1'b0;
			target_upper_half <= 1'b0;
			target_wdata <= 16'h0000;
		end else begin
			target_write <= host_target_write;
			target_read_done <= host_target_read_end;
			if (host_ind_access_end) begin
				target_upper_half <= lane_upper;
			end
			if (host_ind_write) begin
				target_wdata <= write_hold;
			end
		end
	end

	// ==================================================
	// on-chip cpu read port
	wire cpu_read;

	assign cpu_read = cpu_select && !cpu_write;

	// read data holds between reads, so the cpu may sample it late
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cpu_rdata <= 32'h00000000;
		end else if (cpu_read) begin
			if (cpu_reg == `CPU_REG_INDEX) begin
				cpu_rdata <= {24'h000000, index};
			end else begin
				cpu_rdata <= status_word;
			end
		end
	end

endmodule

// File: verilog/host_port_regs.vh
`ifndef HOST_PORT_REGS_VH
`define HOST_PORT_REGS_VH

// ==================================================
// index register layout
`define IDX_WIDTH 8
`define IDX_TGT_MSB 7
`define IDX_TGT_LSB 2
`define IDX_HALF_MSB 1
`define IDX_HALF_LSB 0
`define IDX_RESET 8'h00

// ==================================================
// target select codes
`define TGT_GENERAL_STATUS 6'h00
`define TGT_STATUS_CONTROL 6'h01
`define TGT_MEMORY_CONTROL 6'h02
`define TGT_INBOUND_IRQ 6'h03
`define TGT_OUTBOUND_IRQ 6'h04
`define TGT_ADDRESS_POINTER 6'h05
`define TGT_DATA_WINDOW 6'h06
`define TGT_BOOT_CONTROL 6'h0F

// ==================================================
// halfword select codes
`define HALF_FIRST 2'h0
`define HALF_SECOND 2'h2

// ==================================================
// general status layout
`define GSR_FIELD_WIDTH 16
`define GSR_RESET 16'h0000

// ==================================================
// on-chip cpu register indices
`define CPU_REG_INDEX 1'h0
`define CPU_REG_STATUS 1'h1

// ==================================================
// pin synchroniser idle levels: cs, rs, wr, rd
`define PIN_CTRL_IDLE 4'hB
`define PIN_DATA_IDLE 16'h0000

`endif

// File: verilog/pin_sync.v
`timescale 1ns/1ns

// ==================================================
// two-stage synchroniser, one chain per bit
module pin_sync #(
	parameter W = 1,
	parameter [W-1:0] IDLE = {W{1'b0}}
) (
	input wire clk_sys,
	input wire sys_rst,
	input wire [W-1:0] pin_in,
	output wire [W-1:0] pin_sync_out
);
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			reg meta;
			reg stable;
			// the first stage feeds only the second
			always @(posedge clk_sys or posedge sys_rst) begin
				if (sys_rst) begin
					meta <= IDLE[i];
					stable <= IDLE[i];
				end else begin
					meta <= pin_in[i];
					stable <= meta;
				end
			end
			assign pin_sync_out[i] = stable;
		end
	endgenerate
endmodule

// File: verilog/halfword_lane.v
`timescale 1ns/1ns
`include "host_port_regs.vh"

// ==================================================
// picks one 16-bit half of a word and merges a half back in
module halfword_lane (
	input wire [31:0] word_in,
	input wire [1:0] half_select,
	input wire order_swap,
	input wire [15:0] half_wdata,
	output wire upper_half,
	output wire [15:0] half_rdata,
	output wire [31:0] merged_word
);
	// only the high code bit is decoded; the odd codes are never driven by a well behaved host
	assign upper_half = (half_select[1] == 1'b0) ^ order_swap;
	assign half_rdata = upper_half ? word_in[31:16] : word_in[15:0];
	assign merged_word = upper_half ? {half_wdata, word_in[15:0]} : {word_in[31:16], half_wdata};
endmodule

// File: bench/host_port_index_and_status_checker.sv
`timescale 1ns/1ns
// ==================================================
// port checker
module port_checker (
	input wire clk_sys,
	input wire sys_rst,
	input wire port_rst,
	input wire host_chip_select_n,
	input wire host_write_strobe_n,
	input wire host_read_strobe_n,
	input wire host_data_lines_oe,
	input wire halfword_order_bit,
	input wire cpu_select,
	input wire cpu_reg,
	input wire cpu_write,
	input wire [31:0] cpu_rdata,
	input wire [5:0] target_select_field,
	input wire [1:0] halfword_select,
	input wire target_write,
	input wire target_read_done,
	input wire target_upper_half
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// clocks since a strobe was low; starts full so early cpu writes count
	logic [3:0] quiet;
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			quiet <= 4'hF;
		else if (!host_write_strobe_n || !host_read_strobe_n)
			quiet <= 4'h0;
		else if (quiet != 4'hF)
			quiet <= quiet + 4'h1;
	end
	a_rst_index: assert property ($fell(sys_rst) |->
		{target_select_field, halfword_select} == 8'h00)
		else $error("index not clear after reset");
	a_port_rst: assert property (port_rst |=>
		{target_select_field, halfword_select} == 8'h00)
		else $error("index not clear after port reset");
	a_idx_quiet: assert property (
		$changed({target_select_field, halfword_select}) && !$past(port_rst) |-> quiet < 4'h8)
		else $error("index moved without host access");
	a_cpu_idx: assert property (cpu_select && !cpu_write && !cpu_reg |=>
		cpu_rdata == {24'h0, $past(target_select_field), $past(halfword_select)})
		else $error("cpu index read wrong");
	a_gsr_hi: assert property (cpu_select && !cpu_write && cpu_reg |=>
		cpu_rdata[31:16] == 16'h0)
		else $error("status upper bits not zero");
	a_oe_rise: assert property (
		$fell(host_read_strobe_n) && !host_chip_select_n |-> ##3 host_data_lines_oe)
		else $error("read data not driven");
	a_oe_hold: assert property (host_data_lines_oe |->
		!$past(host_read_strobe_n, 3) || !$past(host_read_strobe_n, 4))
		else $error("data lines driven outside read");
	a_half_pick: assert property (
		(target_write || target_read_done) && target_select_field != 6'h06 |=>
		target_upper_half == ($past(halfword_select[1]) == $past(halfword_order_bit)))
		else $error("wrong half selected");
endmodule

bind host_port_index_and_status port_checker i_chk (.clk_sys, .sys_rst, .port_rst,
	.host_chip_select_n, .host_write_strobe_n, .host_read_strobe_n, .host_data_lines_oe,
	.halfword_order_bit, .cpu_select, .cpu_reg, .cpu_write, .cpu_rdata, .target_select_field,
	.halfword_select, .target_write, .target_read_done, .target_upper_half);

// File: bench/host_model.sv
`timescale 1ns/1ns
// ==================================================
// external host on the parallel port
module host_model (
	input wire clk_sys,
	input wire [15:0] dq_in,
	output logic cs_n,
	output logic rs,
	output logic wr_n,
	output logic rd_n,
	output logic [15:0] dq_out
);
	initial begin
		cs_n = 1'b1;
		rs = 1'b0;
		wr_n = 1'b1;
		rd_n = 1'b1;
		dq_out = 16'h0000;
	end
	// one strobe at a time, six clocks low and six high
	// callers pass only defined codes, half set first
	task automatic acc(input logic w, input logic s, input logic [15:0] d, output logic [15:0] q);
		@(negedge clk_sys);
		cs_n = 1'b0;
		rs = s;
		if (w)
			dq_out = d;
		if (w)
			wr_n = 1'b0;
		else
			rd_n = 1'b0;
		repeat (6) @(negedge clk_sys);
		q = dq_in;
		wr_n = 1'b1;
		rd_n = 1'b1;
		cs_n = 1'b1;
		// released lines must not keep the last value
		dq_out = ~dq_out;
		repeat (6) @(negedge clk_sys);
	endtask
endmodule

// File: bench/host_port_index_and_status_tb_top.sv
`timescale 1ns/1ns
module host_port_index_and_status_tb_top;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic port_rst = 1'b0;
	logic ob = 1'b0;
	logic cpu_select = 1'b0;
	logic cpu_reg = 1'b0;
	logic cpu_write = 1'b0;
	logic [31:0] cpu_wdata = 32'h0;
	logic [31:0] trw = 32'h0;
	logic [31:0] v;
	logic [15:0] q;
	logic up;
	logic [15:0] exp_half;
	wire [31:0] cpu_rdata;
	wire [15:0] dout, hdq, twd;
	wire [5:0] tsf;
	wire [1:0] hs;
	wire oe, cs_n, rs, wr_n, rd_n, tw, trd, tuh;
	wire [15:0] pins = oe ? dout : hdq;
	logic [5:0] codes [8] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h0F};
	int m_idx = 0;
	int m_gsr = 0;
	int err_total = 0;
	int total_checks = 0;
	int m_tgt = 0;
	int n_tw = 0;
	int n_trd = 0;
	always #20 clk_sys = ~clk_sys;
	// pulses are counted on the sampling edge, so a stuck strobe shows up as extra counts
	always @(posedge clk_sys) begin
		if (tw === 1'b1)
			n_tw++;
		if (trd === 1'b1)
			n_trd++;
	end
	host_model i_host (.clk_sys(clk_sys), .dq_in(pins), .cs_n(cs_n), .rs(rs), .wr_n(wr_n),
		.rd_n(rd_n), .dq_out(hdq));
	host_port_index_and_status i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .port_rst(port_rst),
		.host_chip_select_n(cs_n), .register_select_pin(rs), .host_write_strobe_n(wr_n),
		.host_read_strobe_n(rd_n), .host_data_lines_in(pins), .host_data_lines_out(dout),
		.host_data_lines_oe(oe), .halfword_order_bit(ob), .cpu_select(cpu_select),
		.cpu_reg(cpu_reg), .cpu_write(cpu_write), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
		.target_select_field(tsf), .halfword_select(hs), .target_rdata(trw), .target_write(tw),
		.target_read_done(trd), .target_upper_half(tuh), .target_wdata(twd));
	task automatic report_and_stop;
		$display("checks=%0d errors=%0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cpu(input logic r, input logic w, input logic [31:0] d);
		@(negedge clk_sys);
		cpu_select = 1'b1;
		cpu_reg = r;
		cpu_write = w;
		cpu_wdata = d;
		@(negedge clk_sys);
		cpu_select = 1'b0;
	endtask
	task automatic ck_idx;
		cpu(1'b0, 1'b0, 32'h0);
		chk(cpu_rdata, m_idx);
		chk({tsf, hs}, m_idx);
	endtask
	task automatic ck_gsr;
		cpu(1'b1, 1'b0, 32'h0);
		chk(cpu_rdata, m_gsr);
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		report_and_stop();
	end
	initial begin
		void'($urandom(32'h057D));
		repeat (12) @(negedge clk_sys);
		sys_rst = 1'b0;
		ck_idx();
		ck_gsr();
		cpu(1'b0, 1'b1, 32'hFFFFFFFF);
		ck_idx();
		v = $urandom;
		cpu(1'b1, 1'b1, v);
		m_gsr = v[15:0];
		ck_gsr();
		i_host.acc(1'b0, 1'b1, 16'h0, q);
		chk(q, m_gsr);
		foreach (codes[i]) for (int h = 0; h < 2; h++) begin
			v = $urandom;
			ob = v[0];
			trw = $urandom;
			// the upper data lines carry random junk that the index must drop
			i_host.acc(1'b1, 1'b1, {v[15:8], codes[i], h[0], 1'b0}, q);
			m_idx = {codes[i], h[0], 1'b0};
			ck_idx();
			up = (m_idx[1] == ob);
			i_host.acc(1'b0, 1'b0, 16'h0, q);
			exp_half = up ? trw[31:16] : trw[15:0];
			if (codes[i] == 6'h00)
				exp_half = up ? 16'h0000 : m_gsr[15:0];
			chk(q, exp_half);
			if (codes[i] == 6'h06)
				m_idx ^= 2;
			ck_idx();
			up = (m_idx[1] == ob);
			i_host.acc(1'b1, 1'b0, v[31:16], q);
			if (codes[i] == 6'h00 && !up)
				m_gsr = v[31:16];
			if (codes[i] == 6'h06)
				m_idx ^= 2;
			ck_idx();
			ck_gsr();
			if (codes[i] != 6'h00) begin
				m_tgt++;
				chk({tuh, twd}, {up, v[31:16]});
			end
		end
		@(negedge clk_sys);
		port_rst = 1'b1;
		@(negedge clk_sys);
		port_rst = 1'b0;
		m_idx = 0;
		ck_idx();
		ck_gsr();
		sys_rst = 1'b1;
		@(negedge clk_sys);
		sys_rst = 1'b0;
		m_gsr = 0;
		ck_gsr();
		chk(n_tw, m_tgt);
		chk(n_trd, m_tgt);
		report_and_stop();
	end
endmodule
